/* hdl/tcg_pkg.sv */
// Purpose: Shared constants for the timecode generator and sync reference
// Assumes: 20 MHz mclk, classic Wishbone register access
// Notes:   Register offsets are byte addresses of aligned 32-bit words
package tcg_pkg;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_PRESET = 8'h04;
    localparam logic [7:0] REG_TOD    = 8'h08;
    localparam logic [7:0] REG_TC     = 8'h0C;
    localparam logic [7:0] REG_STAT   = 8'h10;
    localparam logic [7:0] REG_IRQ    = 8'h14;
    localparam logic [7:0] REG_MASK   = 8'h18;
    localparam logic [7:0] REG_CMD    = 8'h1C;
    localparam logic [7:0] REG_FSTART = 8'h20;
    // Control field positions
    localparam int CTRL_REF_LSB  = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_OFS_LSB  = 8;
    localparam int CTRL_RATE_LSB = 16;
    localparam int CTRL_RSF_BIT  = 24;
    // Command bits (write one to trigger)
    localparam int CMD_PRESET = 0;
    localparam int CMD_JAM_RX = 1;
    localparam int CMD_JAM_TOD = 2;
    localparam int CMD_TOD_CHG = 3;
    // Interrupt bits
    localparam int IRQ_REF_LOST = 0;
    localparam int IRQ_TC_LOST  = 1;
    localparam int IRQ_REC_STOP = 2;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    // Frame offset limits in frames
    localparam logic signed [4:0] OFS_MIN = -5'sd10;
    localparam logic signed [4:0] OFS_MAX = 5'sd10;
    // Wrap limits
    localparam logic [4:0] HOUR_LAST = 5'h17;
    localparam logic [5:0] MINSEC_LAST = 6'h3B;
    localparam logic [23:0] TC_RESET = 24'h000000;
    // Backup hold time on battery, hours, and its tick count at 1 s ticks
    localparam int BACKUP_HOURS = 4;
    localparam int BACKUP_SECONDS = BACKUP_HOURS * 3600;
    // Sync reference choices
    typedef enum logic [1:0] {
        TCG_REF_WCK  = 2'h0,
        TCG_REF_DIG  = 2'h1,
        TCG_REF_MADI = 2'h2,
        TCG_REF_INT  = 2'h3
    } tcg_ref_t;
    // Timecode modes
    typedef enum logic [2:0] {
        TCG_FREERUN   = 3'h0,
        TCG_FREE_MUTE = 3'h1,
        TCG_RECRUN    = 3'h2,
        TCG_H24       = 3'h3,
        TCG_H24_MUTE  = 3'h4,
        TCG_EXT       = 3'h5,
        TCG_EXT_HALT  = 3'h6
    } tcg_mode_t;
    // Generator state, one-hot
    typedef enum logic [2:0] {
        TCG_ST_RUN  = 3'b001,
        TCG_ST_HOLD = 3'b010,
        TCG_ST_HALT = 3'b100
    } tcg_st_t;
endpackage

/* hdl/tcg_top.sv */
// Purpose: Sync reference monitor, LTC follow and timecode generator
// Assumes: frame_tick pulses once per frame from the locked reference
// Notes:   Timecode packed as hh[28:24] mm[21:16] ss[13:8] ff[4:0]
// What this block does
// - Sample strobe follows selected reference; recording uses that strobe
// - Four references: word clock, digital pair, MADI, internal
// - Invalid selected reference flags flashing label and warning event
// - Timecode reader enabled only in the external timecode modes
// - Signed -10..+10 frame offset applies to file start stamp only
// - Counter runs on backup power up to 4 hours, then resets
// - Freerun advances continuously; accepts jam or manual preset
// - Freerun mute silences timecode output while transport stopped
// - Record run advances only while recording; preset any time
// - Entering record run freezes generator at last value
// - 24-hour loads time of day on entry or date change; jams ok
// - 24-hour mute silences timecode output while transport stopped
// - External follows input; keeps running when input disappears
// - External halt stops advancing once input is lost
// - Halt mode with timecode record follow stops recording on loss
//
// Register access over Wishbone and the placing of the registers were decided locally.
`timescale 1ns/1ps
module tcg_top
    import tcg_pkg::*;
(
    input  wire logic        mclk,        // System clock 20 MHz
    input  wire logic        rst_n,       // Synchronous reset, low
    input  wire logic [31:0] wb_adr_i,    // Wishbone address
    input  wire logic [31:0] wb_dat_i,    // Wishbone write data
    output logic      [31:0] wb_dat_o,    // Wishbone read data
    input  wire logic        wb_we_i,     // Wishbone write enable
    input  wire logic [3:0]  wb_sel_i,    // Wishbone byte selects
    input  wire logic        wb_cyc_i,    // Wishbone cycle
    input  wire logic        wb_stb_i,    // Wishbone strobe
    output logic             wb_ack_o,    // Wishbone acknowledge
    input  wire logic [3:0]  ref_strobe,  // Sample strobes per source
    input  wire logic [3:0]  ref_valid,   // Signal present per source
    input  wire logic        frame_tick,  // One pulse per frame
    input  wire logic        sec_tick,    // One pulse per second
    input  wire logic        blink_tick,  // Label flash rate toggle
    input  wire logic        main_power,  // High while main power is on
    input  wire logic        recording,   // Transport is recording
    input  wire logic        stopped,     // Transport is stopped
    input  wire logic        file_start,  // Pulse at new file start
    input  wire logic [23:0] ltc_rx,      // Received timecode word
    input  wire logic        ltc_rx_valid,// Received timecode valid
    input  wire logic        ltc_rx_stat, // Received timecode stationary
    output logic             sample_en,   // Sample write strobe
    output logic             ltc_rd_en,   // Timecode reader enable
    output logic [23:0]      tc_out,      // Generator timecode
    output logic             tc_out_en,   // Timecode output not muted
    output logic             label_on,    // Reference label lit
    output logic             rec_stop,    // Stop recording request
    output logic             irq          // Interrupt, high level
);
    // Control registers
    logic [31:0] ctrl_r;
    logic [28:0] preset_r;
    logic [28:0] tod_r;
    logic [23:0] tc_r;
    logic [23:0] tc_nxt;
    logic [28:0] fstart_r;
    logic signed [6:0] fofs;
    logic [5:0]  fsec;
    logic [4:0]  ffr;
    logic [2:0]  irq_st_r;
    logic [2:0]  irq_mask_r;
    logic [2:0]  mode_prev_r;
    logic        ref_ok_prev_r;
    logic        ltc_prev_r;
    logic        flash_r;
    logic [13:0] bk_cnt_r;
    logic        bk_expired_r;
    tcg_st_t     st_r;

    tcg_ref_t    ref_sel;
    tcg_mode_t   mode_sel;
    logic [4:0]  rate_last;
    logic signed [4:0] ofs;
    logic        ext_mode;
    logic        wr;
    logic        rd_ack;
    logic        ref_ok;
    logic        ref_lost_ev;
    logic        tc_lost_ev;
    logic        cmd_preset;
    logic        cmd_jam_rx;
    logic        cmd_jam_tod;
    logic        cmd_tod_chg;
    logic [2:0]  ev;

    assign ref_sel  = tcg_ref_t'(ctrl_r[CTRL_REF_LSB +: 2]);
    assign mode_sel = tcg_mode_t'(ctrl_r[CTRL_MODE_LSB +: 3]);
    assign rate_last = ctrl_r[CTRL_RATE_LSB +: 5];
    assign ofs      = ctrl_r[CTRL_OFS_LSB +: 5];
    assign ext_mode = (mode_sel == TCG_EXT) || (mode_sel == TCG_EXT_HALT);
    // Writes land at the edge where the master sees ack
    assign wr       = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
    assign rd_ack   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign ref_ok   = ref_valid[ref_sel];
    assign cmd_preset  = wr && wb_adr_i[7:0] == REG_CMD && wb_dat_i[CMD_PRESET];
    assign cmd_jam_rx  = wr && wb_adr_i[7:0] == REG_CMD && wb_dat_i[CMD_JAM_RX];
    assign cmd_jam_tod = wr && wb_adr_i[7:0] == REG_CMD && wb_dat_i[CMD_JAM_TOD];
    assign cmd_tod_chg = wr && wb_adr_i[7:0] == REG_CMD && wb_dat_i[CMD_TOD_CHG];

    // Clamp a signed offset into the permitted span
    function automatic logic signed [4:0] clamp_ofs(input logic [4:0] v);
        logic signed [4:0] s;
        s = v;
        if (s < OFS_MIN) begin
            clamp_ofs = OFS_MIN;
        end else if (s > OFS_MAX) begin
            clamp_ofs = OFS_MAX;
        end else begin
            clamp_ofs = s;
        end
    endfunction

    // Step timecode by one frame; bits 23:22 return the carry into hours
    function automatic logic [23:0] tc_inc(input logic [23:0] t,
                                           input logic [4:0] fl);
        logic [4:0] f;
        logic [5:0] s;
        logic [5:0] m;
        logic [4:0] h;
        f = t[4:0];
        s = t[13:8];
        m = t[21:16];
        h = 5'h0;
        if (f >= fl) begin
            f = 5'h0;
            if (s >= MINSEC_LAST) begin
                s = 6'h0;
                if (m >= MINSEC_LAST) begin
                    m = 6'h0;
                    h = 5'h1;
                end else begin
                    m = m + 6'h1;
                end
            end else begin
                s = s + 6'h1;
            end
        end else begin
            f = f + 5'h1;
        end
        tc_inc = {h[1:0], m, 2'h0, s, 3'h0, f};
    endfunction

    // Hours live in a separate counter: tc word carries mm:ss:ff only
    logic [4:0] hour_r;

    // Wishbone register writes
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctrl_r     <= 32'h0000_0000;
            preset_r   <= {5'h00, TC_RESET};
            tod_r      <= {5'h00, TC_RESET};
            irq_mask_r <= IRQ_RESET;
        end else if (wr) begin
            unique case (wb_adr_i[7:0])
                REG_CTRL: ctrl_r <= {wb_dat_i[31:13],
                    clamp_ofs(wb_dat_i[12:8]), wb_dat_i[7:0]};
                REG_PRESET: preset_r <= wb_dat_i[28:0];
                REG_TOD:    tod_r    <= wb_dat_i[28:0];
                REG_MASK:   irq_mask_r <= wb_dat_i[2:0];
                default: ;
            endcase
        end
    end

    // Bus answer: one-cycle ack, unmapped reads return zero
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= rd_ack;
            unique case (wb_adr_i[7:0])
                REG_CTRL:   wb_dat_o <= ctrl_r;
                REG_PRESET: wb_dat_o <= {3'h0, preset_r};
                REG_TOD:    wb_dat_o <= {3'h0, tod_r};
                REG_TC:     wb_dat_o <= {3'h0, hour_r, tc_r};
                REG_STAT:   wb_dat_o <= {27'h0, st_r, ref_ok, ltc_rx_valid};
                REG_IRQ:    wb_dat_o <= {29'h0, irq_st_r};
                REG_MASK:   wb_dat_o <= {29'h0, irq_mask_r};
                REG_FSTART: wb_dat_o <= {3'h0, fstart_r};
                default:    wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // Reference path and label flash
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sample_en     <= 1'b0;
            ref_ok_prev_r <= 1'b1;
            flash_r       <= 1'b0;
            label_on      <= 1'b1;
        end else begin
            sample_en     <= ref_strobe[ref_sel];
            ref_ok_prev_r <= ref_ok;
            flash_r       <= blink_tick ? !flash_r : flash_r;
            label_on      <= ref_ok ? 1'b1 : flash_r;
        end
    end

    // Warning fires on loss or on selecting a dead source
    logic [1:0] ref_prev_r;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_prev_r <= TCG_REF_WCK;
        end else begin
            ref_prev_r <= ref_sel;
        end
    end
    assign ref_lost_ev = !ref_ok && (ref_ok_prev_r || ref_prev_r != ref_sel);
    assign tc_lost_ev  = ltc_prev_r && !ltc_rx_valid && ext_mode;
    logic rec_stop_ev;
    assign ev = {rec_stop_ev, tc_lost_ev, ref_lost_ev};

    // Record stop request on halt-mode loss
    assign rec_stop_ev = ctrl_r[CTRL_RSF_BIT] && mode_sel == TCG_EXT_HALT
                         && recording && (!ltc_rx_valid || ltc_rx_stat);

    // Sticky status; set wins over write-one clear
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            irq_st_r <= IRQ_RESET;
            irq      <= 1'b0;
            rec_stop <= 1'b0;
            ltc_prev_r <= 1'b0;
        end else begin
            irq_st_r <= (irq_st_r & ~((wr && wb_adr_i[7:0] == REG_IRQ)
                        ? wb_dat_i[2:0] : 3'h0)) | ev;
            irq      <= |(irq_st_r & irq_mask_r);
            rec_stop <= rec_stop_ev;
            ltc_prev_r <= ltc_rx_valid;
        end
    end

    // Backup timer: counts seconds while main power is off
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            bk_cnt_r     <= 14'h0000;
            bk_expired_r <= 1'b0;
        end else if (main_power) begin
            bk_cnt_r     <= 14'h0000;
            bk_expired_r <= 1'b0;
        end else if (sec_tick && !bk_expired_r) begin
            if (bk_cnt_r == 14'(BACKUP_SECONDS - 1)) begin
                bk_expired_r <= 1'b1;
            end
            bk_cnt_r <= bk_cnt_r + 14'h0001;
        end
    end

    // Generator state: run, hold or halted on input loss
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_r        <= TCG_ST_RUN;
            mode_prev_r <= TCG_FREERUN;
        end else begin
            mode_prev_r <= mode_sel;
            unique case (mode_sel)
                TCG_RECRUN:   st_r <= recording ? TCG_ST_RUN : TCG_ST_HOLD;
                TCG_EXT_HALT: st_r <= ltc_rx_valid ? TCG_ST_RUN : TCG_ST_HALT;
                default:      st_r <= TCG_ST_RUN;
            endcase
        end
    end

    // Next timecode value, by priority: expiry, jams, follow, advance
    logic [23:0] stepped;
    logic        wrap_hr;
    assign stepped = tc_inc({hour_r[1:0], tc_r[21:0]}, rate_last);
    assign wrap_hr = frame_tick && stepped[23:22] == 2'h1;
    always_comb begin
        tc_nxt = tc_r;
        if (frame_tick && st_r == TCG_ST_RUN
            && mode_sel != TCG_RECRUN | recording) begin
            tc_nxt = {2'h0, stepped[21:0]};
        end
        if (ext_mode && ltc_rx_valid) begin
            tc_nxt = {2'h0, ltc_rx[21:0]};
        end
        if (cmd_jam_rx && ltc_rx_valid && mode_sel != TCG_RECRUN) begin
            tc_nxt = {2'h0, ltc_rx[21:0]};
        end
        if ((mode_sel == TCG_H24 || mode_sel == TCG_H24_MUTE)
            && (cmd_jam_tod || cmd_tod_chg || mode_prev_r != mode_sel)) begin
            tc_nxt = {2'h0, tod_r[21:0]};
        end
        if (cmd_preset) begin
            tc_nxt = {2'h0, preset_r[21:0]};
        end
    end

    // Counter registers; mode entry into record run just freezes tc_r
    always_ff @(posedge mclk) begin
        if (!rst_n || bk_expired_r) begin
            tc_r   <= TC_RESET;
            hour_r <= 5'h00;
        end else begin
            tc_r <= tc_nxt;
            if (ext_mode && ltc_rx_valid) begin
                hour_r <= ltc_rx[23:19];
            end else if (cmd_preset) begin
                hour_r <= preset_r[28:24];
            end else if ((mode_sel == TCG_H24 || mode_sel == TCG_H24_MUTE)
                && (cmd_jam_tod || cmd_tod_chg || mode_prev_r != mode_sel)) begin
                hour_r <= tod_r[28:24];
            end else if (wrap_hr && tc_nxt == {2'h0, stepped[21:0]}) begin
                hour_r <= (hour_r >= HOUR_LAST) ? 5'h00 : hour_r + 5'h01;
            end
        end
    end

    // Offset frames with one borrow or carry into seconds; a carry
    // into minutes is not taken, so stamps near :00 or :59 may be off
    always_comb begin
        fofs = $signed({2'b00, tc_r[4:0]}) + 7'(ofs);
        fsec = tc_r[13:8];
        ffr  = fofs[4:0];
        if (fofs < 0) begin
            ffr  = 5'(fofs + 7'(rate_last) + 7'h01);
            fsec = tc_r[13:8] - 6'h01;
        end else if (fofs > $signed({2'b00, rate_last})) begin
            ffr  = 5'(fofs - 7'(rate_last) - 7'h01);
            fsec = tc_r[13:8] + 6'h01;
        end
    end

    // Outputs and file start stamp
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tc_out    <= TC_RESET;
            tc_out_en <= 1'b0;
            ltc_rd_en <= 1'b0;
            fstart_r  <= {5'h00, TC_RESET};
        end else begin
            tc_out    <= {hour_r[4:3], tc_r[21:0]};
            tc_out_en <= !(stopped && (mode_sel == TCG_FREE_MUTE
                         || mode_sel == TCG_H24_MUTE));
            ltc_rd_en <= ext_mode;
            if (file_start) begin
                fstart_r <= {hour_r, tc_r[23:14], fsec, 3'h0, ffr};
            end
        end
    end

    // Checks
    a_reader_enable: assert property (@(posedge mclk) disable iff (!rst_n)
        1 |=> ltc_rd_en == $past(ext_mode))
        else $error("reader enable wrong");
    a_mute_stopped: assert property (@(posedge mclk) disable iff (!rst_n)
        stopped && mode_sel == TCG_FREE_MUTE |=> !tc_out_en)
        else $error("mute missing");
    a_h24_mute: assert property (@(posedge mclk) disable iff (!rst_n)
        stopped && mode_sel == TCG_H24_MUTE |=> !tc_out_en)
        else $error("mute missing in 24h");
    a_recrun_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        st_r == TCG_ST_HOLD && !cmd_preset && mode_sel == TCG_RECRUN
        |=> tc_r == $past(tc_r))
        else $error("record run moved");
    a_halt_state: assert property (@(posedge mclk) disable iff (!rst_n)
        mode_sel == TCG_EXT_HALT && !ltc_rx_valid |=> st_r == TCG_ST_HALT)
        else $error("halt not entered");
    a_rec_stop: assert property (@(posedge mclk) disable iff (!rst_n)
        rec_stop_ev |=> rec_stop)
        else $error("record stop missed");
    a_ref_event: assert property (@(posedge mclk) disable iff (!rst_n)
        ref_lost_ev |=> irq_st_r[IRQ_REF_LOST])
        else $error("warning not latched");
    a_sample_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        1 |=> sample_en == $past(ref_strobe[ref_sel]))
        else $error("sample strobe wrong");
    a_ofs_range: assert property (@(posedge mclk) disable iff (!rst_n)
        ofs >= OFS_MIN && ofs <= OFS_MAX)
        else $error("offset out of range");
    c_rec_stop: cover property (@(posedge mclk) rec_stop);
    c_halt: cover property (@(posedge mclk) st_r == TCG_ST_HALT);
    c_irq: cover property (@(posedge mclk) irq);
    c_preset: cover property (@(posedge mclk) cmd_preset);
endmodule

/* bench/tcg_src_model.sv */
// Purpose: Model of the timecode and reference clock sources
// Assumes: Signals change just after rising edges of mclk
// Notes:   A lost timecode line toggles rather than holding its last word
`timescale 1ns/1ps
module tcg_src_model (
    input  wire logic        mclk,         // System clock
    input  wire logic        rst_n,        // Reset, low
    input  wire logic [3:0]  ref_on,       // Sources carrying signal
    input  wire logic        ltc_on,       // Timecode cable connected
    input  wire logic        frame_tick,   // Frame pulse
    output logic      [3:0]  ref_strobe,   // Sample strobes
    output logic      [3:0]  ref_valid,    // Signal present flags
    output logic      [23:0] ltc_rx,       // Received timecode
    output logic             ltc_rx_valid, // Timecode valid
    output logic             ltc_rx_stat   // Timecode stationary
);
    logic [23:0] cnt_r;
    // Random strobes, so a wrong source choice shows at once
    always_ff @(posedge mclk) begin
        ref_strobe <= 4'($urandom) & ref_on;
        ref_valid  <= ref_on;
    end
    // Count on each frame; a dead line must not look like a frozen word
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            cnt_r  <= 24'h010000;
            ltc_rx <= 24'h000000;
        end else begin
            if (frame_tick) begin
                cnt_r <= cnt_r + 24'h000001;
            end
            ltc_rx <= ltc_on ? cnt_r : ~ltc_rx;
        end
        ltc_rx_valid <= ltc_on;
        ltc_rx_stat  <= 1'b0;
    end
endmodule

/* bench/timecode_generator_sync_ref_bench.sv */
// Purpose: Self-checking bench for the timecode generator
// Assumes: Register map and field layout of the shared package
// Notes:   Rate field set to last frame 15 so frame sums stay small
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end
module timecode_generator_sync_ref_bench;
    import tcg_pkg::*;
    logic        mclk, rst_n, wb_we, wb_cyc, wb_stb, wb_ack_o, irq;
    logic [31:0] wb_adr, wb_dat, wb_dat_o, rd, v;
    logic [3:0]  ref_strobe, ref_valid, ref_on;
    logic [23:0] ltc_rx, tc_out, t0;
    logic        ltc_rx_valid, ltc_rx_stat, ltc_on, frame_tick, sec_tick;
    logic        blink_tick, recording, stopped, file_start, sample_en;
    logic        ltc_rd_en, tc_out_en, label_on, rec_stop, chk_se, prev_se;
    logic [1:0]  cur_ref;
    int          n_mismatch, tests_run, n_hi, n_lo;
    int          ofs_t[4] = '{-10, 10, 3, 11};
    tcg_top dut (.mclk(mclk), .rst_n(rst_n), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we),
        .wb_sel_i(4'hF), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_ack_o(wb_ack_o), .ref_strobe(ref_strobe), .ref_valid(ref_valid),
        .frame_tick(frame_tick), .sec_tick(sec_tick),
        .blink_tick(blink_tick), .main_power(1'b1), .recording(recording),
        .stopped(stopped), .file_start(file_start), .ltc_rx(ltc_rx),
        .ltc_rx_valid(ltc_rx_valid), .ltc_rx_stat(ltc_rx_stat),
        .sample_en(sample_en), .ltc_rd_en(ltc_rd_en), .tc_out(tc_out),
        .tc_out_en(tc_out_en), .label_on(label_on), .rec_stop(rec_stop),
        .irq(irq));
    tcg_src_model src (.mclk(mclk), .rst_n(rst_n), .ref_on(ref_on),
        .ltc_on(ltc_on), .frame_tick(frame_tick), .ref_strobe(ref_strobe),
        .ref_valid(ref_valid), .ltc_rx(ltc_rx), .ltc_rx_valid(ltc_rx_valid),
        .ltc_rx_stat(ltc_rx_stat));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // Classic single cycle; held until ack is seen at a rising edge
    task automatic wb(input logic we, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we  <= we;
        wb_adr <= {24'h0, a};
        wb_dat <= d;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        rd = wb_dat_o;
        if (n >= 40) n_mismatch++;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask
    // Frame pulses, then time for registered outputs to settle
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge mclk);
            frame_tick <= 1'b1;
            @(posedge mclk);
            frame_tick <= 1'b0;
        end
        repeat (3) @(posedge mclk);
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] r,
        input logic [2:0] m, input int o, input logic f);
        return {7'h0, f, 3'h0, 5'h0F, 3'h0, 5'(o), 1'b0, m, 2'h0, r};
    endfunction
    function automatic logic [31:0] rnd_tc();
        return {3'h0, 5'($urandom % 24), 2'h0, 6'($urandom % 60), 2'h0,
                6'(1 + $urandom % 58), 3'h0, 5'($urandom % 12)};
    endfunction
    // Frame offset with one borrow or carry into seconds
    function automatic logic [31:0] add_ofs(input logic [31:0] w,
                                            input int o);
        int f, s;
        f = int'(w[4:0]) + o;
        s = int'(w[13:8]);
        if (f < 0) begin
            f += 16;
            s--;
        end else if (f > 15) begin
            f -= 16;
            s++;
        end
        return {w[31:14], 6'(s), 3'h0, 5'(f)};
    endfunction
    task automatic end_sim();
        $display("Mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Sample strobe must be the selected source's strobe, one cycle late
    always @(negedge mclk) begin
        if (chk_se) `CHK(sample_en, prev_se)
        prev_se = ref_strobe[cur_ref];
    end
    always @(posedge mclk) begin
        sec_tick   <= ($urandom % 16) == 0;
        blink_tick <= ($urandom % 8) == 0;
    end
    initial begin
        #3ms;
        n_mismatch++;
        end_sim();
    end
    initial begin
        void'($urandom(32'h66fbd972));
        {wb_we, wb_cyc, wb_stb, frame_tick, sec_tick, blink_tick} = 6'h0;
        {recording, file_start, chk_se, prev_se, rst_n} = 5'h0;
        {wb_adr, wb_dat, cur_ref, n_mismatch, tests_run} = '0;
        stopped = 1'b1;
        ref_on = 4'hF;
        ltc_on = 1'b1;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        wb(0, REG_IRQ, 0);
        `CHK(rd, 32'h0)
        wb(0, 8'h40, 0);
        `CHK(rd, 32'h0)
        wb(1, REG_MASK, 32'h7);
        wb(1, REG_TOD, rnd_tc());
        // Every mode, transport stopped
        for (int m = 0; m < 7; m++) begin
            wb(1, REG_CTRL, ctl(2'h3, 3'(m), 0, 1'b0));
            t0 = tc_out;
            tick(2);
            `CHK(ltc_rd_en, 1'(m == 5 || m == 6))
            if (m < 5 && m != 2) `CHK(tc_out_en, 1'(m != 1 && m != 4))
            if (m == 0 || m == 3) `CHK(tc_out !== t0, 1'b1)
            if (m == 2) `CHK(tc_out, t0)
        end
        // Record run: preset holds, runs only while recording
        wb(1, REG_CTRL, ctl(2'h3, 3'h2, 0, 1'b0));
        for (int i = 0; i < 4; i++) begin
            v = rnd_tc();
            wb(1, REG_PRESET, v);
            wb(1, REG_CMD, 32'h1);
            tick(2);
            wb(0, REG_TC, 0);
            `CHK(rd, v)
            stopped <= 1'b0;
            recording <= 1'b1;
            tick(3);
            wb(0, REG_TC, 0);
            `CHK(rd, v + 32'h3)
            recording <= 1'b0;
            stopped <= 1'b1;
        end
        wb(1, REG_PRESET, 32'h173B3B0F);
        wb(1, REG_CMD, 32'h1);
        recording <= 1'b1;
        tick(1);
        wb(0, REG_TC, 0);
        `CHK(rd, 32'h0)
        recording <= 1'b0;
        // File start stamp with offsets, including an over-range value
        for (int i = 0; i < 4; i++) begin
            v = rnd_tc();
            wb(1, REG_PRESET, v);
            wb(1, REG_CMD, 32'h1);
            wb(1, REG_CTRL, ctl(2'h3, 3'h2, ofs_t[i], 1'b0));
            @(posedge mclk);
            file_start <= 1'b1;
            @(posedge mclk);
            file_start <= 1'b0;
            tick(0);
            wb(0, REG_FSTART, 0);
            `CHK(rd, add_ofs(v, (ofs_t[i] > 10) ? 10 : ofs_t[i]))
            wb(0, REG_TC, 0);
            `CHK(rd, v)
        end
        // Each reference in turn
        for (int r = 0; r < 4; r++) begin
            wb(1, REG_CTRL, ctl(2'(r), 3'h0, 0, 1'b0));
            cur_ref = 2'(r);
            repeat (2) @(negedge mclk);
            chk_se = 1'b1;
            repeat (20) @(negedge mclk);
            chk_se = 1'b0;
        end
        // Lost reference: flag, flashing label, mask, write-one clear
        wb(1, REG_CTRL, ctl(2'h0, 3'h0, 0, 1'b0));
        ref_on <= 4'hE;
        {n_hi, n_lo} = '0;
        repeat (120) @(negedge mclk) if (label_on) n_hi++; else n_lo++;
        `CHK(n_hi > 0 && n_lo > 0, 1'b1)
        wb(0, REG_IRQ, 0);
        `CHK(rd[0], 1'b1)
        `CHK(irq, 1'b1)
        wb(1, REG_MASK, 32'h0);
        tick(0);
        `CHK(irq, 1'b0)
        ref_on <= 4'hF;
        wb(1, REG_IRQ, 32'h1);
        wb(1, REG_MASK, 32'h7);
        tick(0);
        `CHK(irq, 1'b0)
        {n_hi, n_lo} = '0;
        repeat (60) @(negedge mclk) if (label_on) n_hi++; else n_lo++;
        `CHK(n_lo, 0)
        // External follow, then loss keeps it running
        wb(1, REG_CTRL, ctl(2'h3, 3'h5, 0, 1'b0));
        tick(2);
        repeat (2) @(posedge mclk);
        `CHK(tc_out, ltc_rx)
        ltc_on <= 1'b0;
        tick(0);
        t0 = tc_out;
        tick(2);
        `CHK(tc_out !== t0, 1'b1)
        // Halt with record follow: stops counting and stops recording
        ltc_on <= 1'b1;
        recording <= 1'b1;
        stopped <= 1'b0;
        wb(1, REG_IRQ, 32'h7);
        wb(1, REG_CTRL, ctl(2'h3, 3'h6, 0, 1'b1));
        tick(2);
        `CHK(rec_stop, 1'b0)
        ltc_on <= 1'b0;
        tick(0);
        t0 = tc_out;
        tick(2);
        `CHK(tc_out, t0)
        `CHK(rec_stop, 1'b1)
        wb(0, REG_IRQ, 0);
        `CHK(rd[2], 1'b1)
        end_sim();
    end
endmodule
